// ===== hw/slot_power_control_status_regs.sv
// dual-slot power control and status register bank behind the command-code port
// ----------------------------------------
// ----------------------------------------
module slot_power_control_status_regs (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] cmdCode,
  input wire logic writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic readStrobe,
  output logic [7:0] readData,
  output logic readValid,
  input wire slot_power_pkg::slot_in_t slotAIn,
  input wire slot_power_pkg::slot_in_t slotBIn,
  output slot_power_pkg::slot_out_t slotAOut,
  output slot_power_pkg::slot_out_t slotBOut,
  output logic interruptOut_n
);

  localparam int FW = slot_power_pkg::OC_FLAG_COUNT;

  logic [7:0] ctrlA_r;
  logic [7:0] ctrlB_r;
  logic [7:0] readData_r;
  logic [7:0] readData_nxt;
  logic readValid_r;
  logic interrupt_n_r;
  logic [7:0] slot_a_status;
  logic [7:0] slot_b_status;
  logic [FW-1:0] flagsA;
  logic [FW-1:0] flagsB;
  logic [FW-1:0] clearA;
  logic [FW-1:0] clearB;
  logic slot_a_fault_out_n_n;
  logic slot_b_fault_out_n_n;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // control byte view: power-good on top, enables at the bottom, the rest zero
  function automatic logic [7:0] ctrlView(input logic [7:0] stored,
                                          input slot_power_pkg::slot_in_t s);
    logic [7:0] v;
    v = 8'h00;
    v[slot_power_pkg::CTRL_AUX_GOOD_BIT] = s.auxPowerGood;
    v[slot_power_pkg::CTRL_MAIN_GOOD_BIT] = s.mainPowerGood;
    v[slot_power_pkg::CTRL_MAIN_EN_BIT] = stored[slot_power_pkg::CTRL_MAIN_EN_BIT];
    v[slot_power_pkg::CTRL_AUX_EN_BIT] = stored[slot_power_pkg::CTRL_AUX_EN_BIT];
    return v;
  endfunction : ctrlView

  // only the two enable bits keep what is written
  function automatic logic [7:0] ctrlKeep(input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    v[slot_power_pkg::CTRL_MAIN_EN_BIT] = d[slot_power_pkg::CTRL_MAIN_EN_BIT];
    v[slot_power_pkg::CTRL_AUX_EN_BIT] = d[slot_power_pkg::CTRL_AUX_EN_BIT];
    return v;
  endfunction : ctrlKeep

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrlA_r <= slot_power_pkg::CTRL_RESET;
    end else if (writeStrobe && cmdCode == slot_power_pkg::CMD_CTRL_A) begin
      ctrlA_r <= ctrlKeep(writeData);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrlB_r <= slot_power_pkg::CTRL_RESET;
    end else if (writeStrobe && cmdCode == slot_power_pkg::CMD_CTRL_B) begin
      ctrlB_r <= ctrlKeep(writeData);
    end
  end

  assign slotAOut.mainEnable = ctrlA_r[slot_power_pkg::CTRL_MAIN_EN_BIT];
  assign slotAOut.auxEnable = ctrlA_r[slot_power_pkg::CTRL_AUX_EN_BIT];
  assign slotBOut.mainEnable = ctrlB_r[slot_power_pkg::CTRL_MAIN_EN_BIT];
  assign slotBOut.auxEnable = ctrlB_r[slot_power_pkg::CTRL_AUX_EN_BIT];

  // ----------------------------------------
  // status registers
  // ----------------------------------------
  // upper status bits are read-only, so only the flag lanes carry a clear
  assign clearA = (writeStrobe && cmdCode == slot_power_pkg::CMD_STAT_A) ?
                  writeData[FW-1:0] : '0;
  assign clearB = (writeStrobe && cmdCode == slot_power_pkg::CMD_STAT_B) ?
                  writeData[FW-1:0] : '0;

  slot_status_reg #(
    .FLAG_W(FW)
  ) uStatA (
    .clock(clock),
    .reset(reset),
    .slotIn(slotAIn),
    .clearMask(clearA),
    .statusByte(slot_a_status),
    .flags(flagsA),
    .faultOut_n(slot_a_fault_out_n_n)
  );

  slot_status_reg #(
    .FLAG_W(FW)
  ) uStatB (
    .clock(clock),
    .reset(reset),
    .slotIn(slotBIn),
    .clearMask(clearB),
    .statusByte(slot_b_status),
    .flags(flagsB),
    .faultOut_n(slot_b_fault_out_n_n)
  );

  assign slotAOut.faultOut_n = slot_a_fault_out_n_n;
  assign slotBOut.faultOut_n = slot_b_fault_out_n_n;

  // ----------------------------------------
  // interrupt line
  // ----------------------------------------
  // a level: stays low while any flag of either slot is still set
  always_ff @(posedge clock) begin
    if (reset) begin
      interrupt_n_r <= 1'b1;
    end else begin
      interrupt_n_r <= !((|flagsA) || (|flagsB));
    end
  end

  assign interruptOut_n = interrupt_n_r;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // reads are pure muxing: nothing in the slots sees the read strobe
  always_comb begin
    unique case (cmdCode)
      slot_power_pkg::CMD_CTRL_A: readData_nxt = ctrlView(ctrlA_r, slotAIn);
      slot_power_pkg::CMD_CTRL_B: readData_nxt = ctrlView(ctrlB_r, slotBIn);
      slot_power_pkg::CMD_STAT_A: readData_nxt = slot_a_status;
      slot_power_pkg::CMD_STAT_B: readData_nxt = slot_b_status;
      default: readData_nxt = slot_power_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      readData_r <= 8'h00;
    end else if (readStrobe) begin
      readData_r <= readData_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      readValid_r <= 1'b0;
    end else begin
      readValid_r <= readStrobe;
    end
  end

  assign readData = readData_r;
  assign readValid = readValid_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence writeCtrlB;
    writeStrobe && cmdCode == slot_power_pkg::CMD_CTRL_B;
  endsequence

  sequence readCtrlB;
    readStrobe && !writeStrobe && cmdCode == slot_power_pkg::CMD_CTRL_B;
  endsequence

  ctrlResetOff_a: assert property (@(posedge clock)
    $past(reset) |-> !slotAOut.mainEnable && !slotAOut.auxEnable && ctrlA_r == 8'h00)
    else $error("slot A control not zero after reset");

  ctrlBReset_a: assert property (@(posedge clock)
    $past(reset) |-> ctrlB_r == 8'h00 && !slotBOut.mainEnable && !slotBOut.auxEnable)
    else $error("slot B control not zero after reset");

  ctrlBWrite_a: assert property (@(posedge clock) disable iff (reset)
    writeCtrlB |=> slotBOut.mainEnable == $past(writeData[1]) &&
                   slotBOut.auxEnable == $past(writeData[0]))
    else $error("slot B enables do not follow write");

  ctrlBReadback_a: assert property (@(posedge clock) disable iff (reset)
    readCtrlB |=> readValid && readData[7] == $past(slotBIn.auxPowerGood) &&
                  readData[6] == $past(slotBIn.mainPowerGood) && readData[5:2] == 4'h0)
    else $error("slot B control readback wrong");

  statBRead_a: assert property (@(posedge clock) disable iff (reset)
    (readStrobe && cmdCode == slot_power_pkg::CMD_STAT_B) |=>
      readData[6] == $past(slotBIn.mainActualOn) && readData[5] == $past(slotBIn.auxActualOn))
    else $error("slot B status readback wrong");

  intRelease_a: assert property (@(posedge clock) disable iff (reset)
    (flagsA == '0 && flagsB == '0) |=> interruptOut_n)
    else $error("interrupt held with no flags");

  intAssert_a: assert property (@(posedge clock) disable iff (reset)
    (slotAIn.overcurrentEvent != '0) |-> ##2 !interruptOut_n)
    else $error("interrupt missing after trip");

  // slot inputs unchanged and no trip: only a read could still move the pin
  sequence slotAQuiet;
    $stable(slotAIn) && slotAIn.overcurrentEvent == '0;
  endsequence

  readNoFault_a: assert property (@(posedge clock) disable iff (reset)
    slotAQuiet ##1 (slotAQuiet and readStrobe) |=> $stable(slot_a_fault_out_n_n))
    else $error("status read disturbed the fault pin");

endmodule : slot_power_control_status_regs

// ===== hw/slot_power_pkg.sv
// package: command codes, bit layout, reset values and carriers of the slot power registers
package slot_power_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_CTRL_A = 8'h02;
  localparam logic [7:0] CMD_CTRL_B = 8'h03;
  localparam logic [7:0] CMD_STAT_A = 8'h04;
  localparam logic [7:0] CMD_STAT_B = 8'h05;

  // ----------------------------------------
  // reset values and the unmapped read byte
  // ----------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_AUX_GOOD_BIT = 7;
  localparam int CTRL_MAIN_GOOD_BIT = 6;
  localparam int CTRL_MAIN_EN_BIT = 1;
  localparam int CTRL_AUX_EN_BIT = 0;

  // ----------------------------------------
  // status register fields
  // ----------------------------------------
  localparam int STAT_FAULT_PIN_BIT = 7;
  localparam int STAT_MAIN_ON_BIT = 6;
  localparam int STAT_AUX_ON_BIT = 5;
  localparam int OC_FLAG_COUNT = 5;
  localparam int OC_AUX_BIT = 4;
  localparam int OC_NEG12_BIT = 3;
  localparam int OC_POS12_BIT = 2;
  localparam int OC_FIVE_BIT = 1;
  localparam int OC_THREE_BIT = 0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // per-slot analog and pin side, as seen by the logic
  typedef struct packed {
    logic mainPowerGood;
    logic auxPowerGood;
    logic mainActualOn;
    logic auxActualOn;
    logic pinControl;
    logic onPin;
    logic auxEnPin;
    logic [4:0] overcurrentEvent;
  } slot_in_t;

  typedef struct packed {
    logic mainEnable;
    logic auxEnable;
    logic faultOut_n;
  } slot_out_t;

endpackage : slot_power_pkg

// ===== hw/slot_status_reg.sv
// one slot's status register: overcurrent flags, fault pin latch and status byte
module slot_status_reg #(
  parameter int FLAG_W = 5
) (
  input wire logic clock,
  input wire logic reset,
  input wire slot_power_pkg::slot_in_t slotIn,
  input wire logic [FLAG_W-1:0] clearMask,
  output logic [7:0] statusByte,
  output logic [FLAG_W-1:0] flags,
  output logic faultOut_n
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (FLAG_W != slot_power_pkg::OC_FLAG_COUNT) begin : gBadWidth
    $error("slot_status_reg: flag width must match the status layout");
  end

  logic [FLAG_W-1:0] flags_r;
  logic faultMain_r;
  logic faultAux_r;
  logic faultOut_n_r;
  logic faultActive;

  // ----------------------------------------
  // overcurrent flags
  // ----------------------------------------
  // set beats clear so a trip in the clearing cycle is never lost
  always_ff @(posedge clock) begin
    if (reset) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~clearMask) | slotIn.overcurrentEvent;
    end
  end

  // ----------------------------------------
  // fault pin latch
  // ----------------------------------------
  // released only by the enable pins or by dropping pinControl, never by register traffic or reads
  always_ff @(posedge clock) begin
    if (reset) begin
      faultMain_r <= 1'b0;
      faultAux_r <= 1'b0;
    end else if (!slotIn.pinControl) begin
      faultMain_r <= 1'b0;
      faultAux_r <= 1'b0;
    end else begin
      faultMain_r <= slotIn.onPin && (faultMain_r || (|slotIn.overcurrentEvent[3:0]));
      faultAux_r <= slotIn.auxEnPin &&
                    (faultAux_r || slotIn.overcurrentEvent[slot_power_pkg::OC_AUX_BIT]);
    end
  end

  assign faultActive = faultMain_r || faultAux_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      faultOut_n_r <= 1'b1;
    end else begin
      faultOut_n_r <= !faultActive;
    end
  end

  // ----------------------------------------
  // status byte
  // ----------------------------------------
  always_comb begin
    statusByte = slot_power_pkg::STAT_RESET;
    statusByte[slot_power_pkg::STAT_FAULT_PIN_BIT] = !faultOut_n_r;
    statusByte[slot_power_pkg::STAT_MAIN_ON_BIT] = slotIn.mainActualOn;
    statusByte[slot_power_pkg::STAT_AUX_ON_BIT] = slotIn.auxActualOn;
    statusByte[FLAG_W-1:0] = flags_r;
  end

  assign flags = flags_r;
  assign faultOut_n = faultOut_n_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence tripSeen;
    slotIn.overcurrentEvent != '0;
  endsequence

  flagSet_a: assert property (@(posedge clock) disable iff (reset)
    tripSeen |=> ((flags_r & $past(slotIn.overcurrentEvent)) == $past(slotIn.overcurrentEvent)))
    else $error("overcurrent flag not set by trip");

  flagClear_a: assert property (@(posedge clock) disable iff (reset)
    ((clearMask & ~slotIn.overcurrentEvent) != '0) |=>
      ((flags_r & $past(clearMask & ~slotIn.overcurrentEvent)) == '0))
    else $error("written one did not clear flag");

  flagHold_a: assert property (@(posedge clock) disable iff (reset)
    (clearMask == '0 && slotIn.overcurrentEvent == '0) |=> $stable(flags_r))
    else $error("flag changed without trip or clear");

  regModeQuiet_a: assert property (@(posedge clock) disable iff (reset)
    // the latch clears on the first cycle and the pin follows one cycle later
    !slotIn.pinControl ##1 !slotIn.pinControl ##1 !slotIn.pinControl |->
      faultOut_n_r && !statusByte[7])
    else $error("fault active under register control");

  pinBitMatch_a: assert property (@(posedge clock) disable iff (reset)
    (slotIn.pinControl && slotIn.onPin && slotIn.overcurrentEvent[3:0] != '0) |->
      ##2 (!faultOut_n && statusByte[slot_power_pkg::STAT_FAULT_PIN_BIT]))
    else $error("main rail trip did not show on pin and status bit");

endmodule : slot_status_reg

// ===== test/slot_side_model.sv
// slot-side model: output stages that follow the enables or the slot pins
module slot_side_model (
  input wire logic clock,
  input wire slot_power_pkg::slot_out_t slotOut,
  input wire logic pinCtl,
  input wire logic onPin,
  input wire logic auxEnPin,
  input wire logic [4:0] trip,
  output slot_power_pkg::slot_in_t slotIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mainOn_r;
  logic auxOn_r;
  // outputs lag their enable by a cycle, as a real switch never turns on at once
  always_ff @(posedge clock) begin
    mainOn_r <= pinCtl ? onPin : slotOut.mainEnable;
    auxOn_r <= pinCtl ? auxEnPin : slotOut.auxEnable;
  end
  assign slotIn = '{mainPowerGood: mainOn_r, auxPowerGood: auxOn_r, mainActualOn: mainOn_r,
                    auxActualOn: auxOn_r, pinControl: pinCtl, onPin: onPin,
                    auxEnPin: auxEnPin, overcurrentEvent: trip};
endmodule : slot_side_model

// ===== test/test_slot_power_control_status_regs.sv
// self-checking bench of the slot power register bank
module test_slot_power_control_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic reset;
  logic [7:0] cmdCode;
  logic writeStrobe;
  logic [7:0] writeData;
  logic readStrobe;
  logic [7:0] readData;
  logic readValid;
  logic interruptOut_n;
  logic pinCtl [2];
  logic onPin [2];
  logic auxPin [2];
  logic [4:0] trip [2];
  logic [1:0] en [2];
  logic [7:0] d;
  logic [4:0] m;
  slot_power_pkg::slot_in_t slotIn [2];
  slot_power_pkg::slot_out_t slotOut [2];
  logic [7:0] expQ [$];
  int mismatches;
  int comparisons;
  int seed;

  slot_power_control_status_regs dut (.clock(clock), .reset(reset), .cmdCode(cmdCode),
    .writeStrobe(writeStrobe), .writeData(writeData), .readStrobe(readStrobe),
    .readData(readData), .readValid(readValid), .slotAIn(slotIn[0]), .slotBIn(slotIn[1]),
    .slotAOut(slotOut[0]), .slotBOut(slotOut[1]), .interruptOut_n(interruptOut_n));

  for (genvar g = 0; g < 2; g++) begin : side
    slot_side_model model (.clock(clock), .slotOut(slotOut[g]), .pinCtl(pinCtl[g]),
      .onPin(onPin[g]), .auxEnPin(auxPin[g]), .trip(trip[g]), .slotIn(slotIn[g]));
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // step off the edge so checks and pin changes never race the design's flops
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : idle

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clock);
    #2;
    cmdCode = code;
    writeData = data;
    writeStrobe = 1'b1;
    @(posedge clock);
    #2;
    writeStrobe = 1'b0;
  endtask : wr

  // the expected byte is noted at the strobe; the monitor settles it a cycle later
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    @(posedge clock);
    #2;
    cmdCode = code;
    readStrobe = 1'b1;
    expQ.push_back(exp);
    @(posedge clock);
    #2;
    readStrobe = 1'b0;
  endtask : rd

  function automatic logic [7:0] ctl(input int s);
    return (s == 1) ? slot_power_pkg::CMD_CTRL_B : slot_power_pkg::CMD_CTRL_A;
  endfunction : ctl

  function automatic logic [7:0] stat(input int s);
    return (s == 1) ? slot_power_pkg::CMD_STAT_B : slot_power_pkg::CMD_STAT_A;
  endfunction : stat

  function automatic logic [7:0] statExp(input int s, input logic f, input logic [4:0] fl);
    return {f, pinCtl[s] ? onPin[s] : en[s][1], pinCtl[s] ? auxPin[s] : en[s][0], fl};
  endfunction : statExp

  // readValid stands one cycle, so the falling edge inside it is a safe sample point
  always @(negedge clock) begin
    if (readValid === 1'b1) begin
      if (expQ.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t: read answer with none pending", $time);
      end else begin
        check(readData, expQ.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 34325;
    mismatches = 0;
    comparisons = 0;
    reset = 1'b1;
    cmdCode = 8'h00;
    writeStrobe = 1'b0;
    writeData = 8'h00;
    readStrobe = 1'b0;
    for (int s = 0; s < 2; s++) begin
      pinCtl[s] = 1'b0;
      onPin[s] = 1'b0;
      auxPin[s] = 1'b0;
      trip[s] = 5'h00;
      en[s] = 2'h0;
    end
    repeat (6) @(posedge clock);
    #2;
    reset = 1'b0;
    for (int c = 2; c < 8; c++) rd(8'(c), 8'h00);
    for (int s = 0; s < 2; s++) begin
      for (int v = 0; v < 4; v++) begin
        d = 8'($random(seed));
        d[1:0] = v[1:0];
        wr(ctl(s), d);
        en[s] = v[1:0];
        idle(3);
        check({6'h00, slotOut[s].mainEnable, slotOut[s].auxEnable}, {6'h00, en[s]});
        rd(ctl(s), {en[s][0], en[s][1], 4'h0, en[s]});
        rd(stat(s), statExp(s, 1'b0, 5'h00));
      end
    end
    wr(8'h06, 8'h00);
    rd(ctl(0), 8'hc3);
    // overcurrent flags under register control keep the fault pin quiet
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 5; i++) begin
        m = 5'(1 << i);
        trip[s] = m;
        @(posedge clock);
        #2;
        trip[s] = 5'h00;
        idle(3);
        check({7'h00, interruptOut_n}, 8'h00);
        check({7'h00, slotOut[s].faultOut_n}, 8'h01);
        rd(stat(s), statExp(s, 1'b0, m));
        wr(stat(s), 8'he0 | {3'h0, ~m});
        rd(stat(s), statExp(s, 1'b0, m));
        wr(stat(s), {3'h0, m});
        rd(stat(s), statExp(s, 1'b0, 5'h00));
        idle(2);
        check({7'h00, interruptOut_n}, 8'h01);
      end
    end
    // pin control: the fault pin latches and only the slot pin releases it
    for (int s = 0; s < 2; s++) begin
      pinCtl[s] = 1'b1;
      onPin[s] = 1'b1;
      idle(2);
      trip[s] = 5'h01;
      @(posedge clock);
      #2;
      trip[s] = 5'h00;
      idle(3);
      check({7'h00, slotOut[s].faultOut_n}, 8'h00);
      rd(stat(s), statExp(s, 1'b1, 5'h01));
      rd(stat(s), statExp(s, 1'b1, 5'h01));
      wr(stat(s), 8'h01);
      idle(2);
      check({7'h00, slotOut[s].faultOut_n}, 8'h00);
      rd(stat(s), statExp(s, 1'b1, 5'h00));
      onPin[s] = 1'b0;
      idle(4);
      check({7'h00, slotOut[s].faultOut_n}, 8'h01);
      rd(stat(s), statExp(s, 1'b0, 5'h00));
      pinCtl[s] = 1'b0;
    end
    idle(3);
    check(8'(expQ.size()), 8'h00);
    final_report();
  end
endmodule : test_slot_power_control_status_regs
